// ### src/adc_pacing_pkg.sv
// Purpose: Shared constants and types for the pacing sequencer and its controller
// Assumes: core clock 125 MHz
// Notes:   Register map of the sequencer is internal to the link
package adc_pacing_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 125;
  localparam int CONV_FAST_NS      = 10000;
  localparam int CONV_SLOW_NS      = 20000;
  localparam int CONV_FAST_CYC     = (CONV_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_SLOW_CYC     = (CONV_SLOW_NS * CLK_MHZ + 999) / 1000;
  localparam int TB_FAST_MHZ       = 10;
  localparam int TB_SLOW_MHZ       = 1;
  localparam int TB_FAST_DIV       = CLK_MHZ / TB_FAST_MHZ;
  localparam int TB_SLOW_DIV       = CLK_MHZ / TB_SLOW_MHZ;
  localparam int BURST_MAX_HZ      = 100000;
  localparam int BURST_MIN_HZ      = 3940;
  localparam int BURST_MIN_CYC     = CLK_MHZ * 1000000 / BURST_MAX_HZ;
  localparam int BURST_MAX_CYC     = CLK_MHZ * 1000000 / BURST_MIN_HZ;
  localparam int BURST_W           = 16;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SAMPLE_W          = 12;
  localparam int DATA_W            = 16;
  localparam int CHAN_W            = 4;
  localparam int CHAN_SE           = 16;
  localparam int CHAN_DIFF         = 8;
  localparam int EXP_W             = 4;
  localparam int ADDR_W            = 4;

  // ----------------------------------------------------------------
  // Sequencer register map (word offsets)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CHAN    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_DIVLO   = 4'h2;
  localparam logic [ADDR_W-1:0] REG_DIVHI   = 4'h3;
  localparam logic [ADDR_W-1:0] REG_BURST   = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SWSTART = 4'h5;
  localparam logic [ADDR_W-1:0] REG_EXPSEL  = 4'h6;
  localparam logic [ADDR_W-1:0] REG_DATA    = 4'h7;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h8;

  // Control register fields
  localparam int CTRL_SRC_LSB   = 0;   // 2 bits: clock source
  localparam int CTRL_BURST_BIT = 2;
  localparam int CTRL_XFER_LSB  = 3;   // 2 bits: transfer mode
  localparam int CTRL_GATE_BIT  = 5;
  localparam int CTRL_DMA3_BIT  = 6;
  localparam int CTRL_ADCEN_BIT = 7;
  localparam int CTRL_TBF_BIT   = 8;   // Timebase strap image
  localparam int CTRL_DIFF_BIT  = 9;
  localparam int CTRL_SLOW_BIT  = 10;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

  typedef enum logic [1:0] {SRC_SOFT = 2'h0, SRC_INT = 2'h1, SRC_EXT = 2'h2} src_t;
  typedef enum logic [1:0] {XFER_PROG = 2'h0, XFER_IRQ = 2'h1, XFER_DMA = 2'h2} xfer_t;

  // Status fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_BUSY_BIT  = 1;
  localparam int STAT_SCAN_BIT  = 2;
  localparam int STAT_CHAN_LSB  = 4;

  // Controller command register offsets
  localparam logic [ADDR_W-1:0] CMD_ADDR  = 4'h0;
  localparam logic [ADDR_W-1:0] CMD_WDATA = 4'h1;
  localparam logic [ADDR_W-1:0] CMD_GO    = 4'h2;
  localparam logic [ADDR_W-1:0] CMD_STAT  = 4'h3;
  localparam logic [ADDR_W-1:0] CMD_RDATA = 4'h4;
  localparam logic [ADDR_W-1:0] CMD_DMA   = 4'h5;
  localparam int GO_WRITE_BIT = 0;
  localparam int GO_READ_BIT  = 1;

endpackage

// ### src/adc_pacing_if.sv
// Purpose: Link between the acquisition sequencer and its host controller
// Assumes: single core clock for both ends
// Notes:   Host side holds the register port, DMA and interrupt lines
`timescale 1ns/1ps
interface adc_pacing_if;
  import adc_pacing_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic              dmaReq;
  logic              dmaAck;
  logic              dmaChan3;
  logic              tick;

  modport device (input addr, wdata, wr, rd, dmaAck, output rdata, irq, dmaReq, dmaChan3, tick);
  modport host   (output addr, wdata, wr, rd, dmaAck, input rdata, irq, dmaReq, dmaChan3, tick);
endinterface

// ### src/adc_pacing_sequencer.sv
// Purpose: Conversion start selection, pacing and channel sequencing
// Assumes: converter result arrives on convDone with convData
// Notes:   One core clock; the pacer pin passes a two-stage synchroniser, the strap is sampled once
// Function
// - Results twelve-bit, left-justified, offset binary
// - Sixteen single-ended or eight differential channels
// - Paced default: one conversion per pacer pulse
// - Burst: pulse starts scan, burst-clock spaced
// - Burst clock programmable 3.94 to 100 kHz
// - Software keeps pacer under burst rate/channels
// - Pacer timebase strap-selects 1 or 10 MHz
// - Two cascaded counters, divisor up to 2^32
// - Starts limited to 10 or 20 microseconds
// - External pacer never exceeds converter rate
// - External source: rising edges start conversions
// - Software source: starts only on command
// - Idle pacer still raises periodic interrupts
// - Digital outputs drive expansion channel select
// - Gain 500 limits bursts to 10 ks/s
// - Burst works with DMA or interrupt transfer
// - Hardware gate holds pacer until input high
// - Interrupt mode raises request per result
// - DMA mode single-cycle requests, channel 1/3
`timescale 1ns/1ps
module adc_pacing_sequencer
  import adc_pacing_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                reset,
  adc_pacing_if.device             bus,
  input  wire logic                pacerPin,
  input  wire logic                timebaseFast,
  input  wire logic                convDone,
  input  wire logic [SAMPLE_W-1:0] convData,
  output logic                     convStart,
  output logic [CHAN_W-1:0]        muxChan,
  output logic [EXP_W-1:0]         expSelect
);
  import adc_pacing_pkg::*;

  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_CONV = 3'b010, ST_SPACE = 3'b100} state_t;

  logic [DATA_W-1:0]   ctrl_q;
  logic [CHAN_W-1:0]   firstChan_q, lastChan_q, chan_q;
  logic [31:0]         divisor_q;
  logic [BURST_W-1:0]  burstDiv_q;
  logic [EXP_W-1:0]    expSel_q;
  logic [DATA_W-1:0]   result_q, rdata_q;
  logic                ready_q, swStart_q, tbStrap_q, strapDone_q;
  logic                pinMeta_q, pinSync_q, pinPrev_q;
  logic [7:0]          tbCnt_q;
  logic [15:0]         stage1_q, stage2_q;
  logic                tick_q, convStart_q, dmaReq_q, scanning_q;
  logic [BURST_W-1:0]  spaceCnt_q;
  logic [15:0]         guardCnt_q;
  state_t              state_q;

  src_t  src;
  xfer_t xfer;
  logic  burstMode, gateEn, pacerPulse, startReq, guardOk, tbTick, atLast;
  logic  [CHAN_W-1:0] chanTop;

  assign src       = src_t'(ctrl_q[CTRL_SRC_LSB +: 2]);
  assign xfer      = xfer_t'(ctrl_q[CTRL_XFER_LSB +: 2]);
  assign burstMode = ctrl_q[CTRL_BURST_BIT];
  assign gateEn    = ctrl_q[CTRL_GATE_BIT];
  assign chanTop   = ctrl_q[CTRL_DIFF_BIT] ? CHAN_W'(CHAN_DIFF - 1) : CHAN_W'(CHAN_SE - 1);
  assign atLast    = (chan_q == lastChan_q);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  function automatic logic [CHAN_W-1:0] clampChan(input logic [CHAN_W-1:0] c, input logic [CHAN_W-1:0] top);
    clampChan = (c > top) ? top : c;
  endfunction

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q      <= CTRL_RESET;  // Paced mode by default
      firstChan_q <= '0;
      lastChan_q  <= '0;
      divisor_q   <= '0;
      burstDiv_q  <= BURST_W'(BURST_MIN_CYC);
      expSel_q    <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        REG_CTRL:  ctrl_q <= bus.wdata;
        REG_CHAN: begin
          firstChan_q <= clampChan(bus.wdata[CHAN_W-1:0], chanTop);
          lastChan_q  <= clampChan(bus.wdata[8 +: CHAN_W], chanTop);
        end
        REG_DIVLO: divisor_q[15:0]  <= bus.wdata;
        REG_DIVHI: divisor_q[31:16] <= bus.wdata;
        // Clamped so the burst clock stays inside 3.94..100 kHz
        REG_BURST: burstDiv_q <= (bus.wdata < BURST_W'(BURST_MIN_CYC)) ? BURST_W'(BURST_MIN_CYC) :
                                 (bus.wdata > BURST_W'(BURST_MAX_CYC)) ? BURST_W'(BURST_MAX_CYC) :
                                 bus.wdata;
        REG_EXPSEL: expSel_q <= bus.wdata[EXP_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) swStart_q <= 1'b0;
    else       swStart_q <= bus.wr && bus.addr == REG_SWSTART && src == SRC_SOFT;
  end

  // Strap caught after reset release, never under reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tbStrap_q   <= 1'b0;
      strapDone_q <= 1'b0;
    end else if (!strapDone_q) begin
      tbStrap_q   <= timebaseFast;
      strapDone_q <= 1'b1;
    end
  end

  // Result holding and ready flag; new result wins over read clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      result_q <= '0;
      ready_q  <= 1'b0;
    end else if (convDone) begin
      result_q <= {convData, {(DATA_W-SAMPLE_W){1'b0}}};
      ready_q  <= 1'b1;
    end else if ((bus.rd && bus.addr == REG_DATA) || (dmaReq_q && bus.dmaAck)) begin
      ready_q  <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) rdata_q <= '0;
    else if (bus.rd) begin
      case (bus.addr)
        REG_CTRL:   rdata_q <= ctrl_q | (DATA_W'(tbStrap_q) << CTRL_TBF_BIT);
        REG_CHAN:   rdata_q <= DATA_W'({lastChan_q, 4'h0, firstChan_q});
        REG_DIVLO:  rdata_q <= divisor_q[15:0];
        REG_DIVHI:  rdata_q <= divisor_q[31:16];
        REG_BURST:  rdata_q <= burstDiv_q;
        REG_EXPSEL: rdata_q <= DATA_W'(expSel_q);
        REG_DATA:   rdata_q <= result_q;
        REG_STATUS: rdata_q <= DATA_W'({chan_q, 1'b0, scanning_q, state_q != ST_IDLE, ready_q});
        default:    rdata_q <= '0;
      endcase
    end else if (dmaReq_q) rdata_q <= result_q;
    else rdata_q <= '0;
  end

  // ----------------------------------------------------------------
  // Pacer pin synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
      pinPrev_q <= 1'b0;
    end else begin
      pinMeta_q <= pacerPin;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  // ----------------------------------------------------------------
  // Internal pacer: timebase then two cascaded 16-bit stages
  // ----------------------------------------------------------------
  assign tbTick = (tbCnt_q == 8'h00);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) tbCnt_q <= '0;
    else if (tbTick) tbCnt_q <= tbStrap_q ? 8'(TB_FAST_DIV - 1) : 8'(TB_SLOW_DIV - 1);
    else tbCnt_q <= tbCnt_q - 8'h01;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
      tick_q   <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (tbTick) begin
        if (stage1_q <= 16'h0001) begin
          stage1_q <= divisor_q[15:0];
          if (stage2_q <= 16'h0001) begin
            stage2_q <= divisor_q[31:16];
            tick_q   <= 1'b1;
          end else stage2_q <= stage2_q - 16'h0001;
        end else stage1_q <= stage1_q - 16'h0001;
      end
    end
  end

  // Gate holds pacer pulses off until the shared pin is high
  always_comb begin
    case (src)
      SRC_INT: pacerPulse = tick_q && (!gateEn || pinSync_q);
      SRC_EXT: pacerPulse = pinSync_q && !pinPrev_q;
      default: pacerPulse = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Too-fast pacer and software starts are dropped rather than queued; burst scan starts in ST_SPACE wait for the guard
  assign guardOk  = (guardCnt_q == 16'h0000);
  assign startReq = ctrl_q[CTRL_ADCEN_BIT] && (pacerPulse || swStart_q);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) guardCnt_q <= '0;
    else if (convStart_q)
      guardCnt_q <= ctrl_q[CTRL_SLOW_BIT] ? 16'(CONV_SLOW_CYC - 1) : 16'(CONV_FAST_CYC - 1);
    else if (!guardOk) guardCnt_q <= guardCnt_q - 16'h0001;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q     <= ST_IDLE;
      chan_q      <= '0;
      convStart_q <= 1'b0;
      scanning_q  <= 1'b0;
      spaceCnt_q  <= '0;
    end else begin
      convStart_q <= 1'b0;
      // New list restarts the pointer at its first channel, unless convDone advances it in the same cycle
      if (bus.wr && bus.addr == REG_CHAN) chan_q <= clampChan(bus.wdata[CHAN_W-1:0], chanTop);
      case (state_q)
        ST_IDLE: if (startReq && guardOk) begin
          convStart_q <= 1'b1;
          scanning_q  <= burstMode && src != SRC_SOFT;
          state_q     <= ST_CONV;
        end
        ST_CONV: if (convDone) begin
          chan_q <= atLast ? firstChan_q : chan_q + CHAN_W'(1);
          if (scanning_q && !atLast) begin
            spaceCnt_q <= burstDiv_q;
            state_q    <= ST_SPACE;
          end else begin
            scanning_q <= 1'b0;
            state_q    <= ST_IDLE;
          end
        end
        ST_SPACE: begin
          if (spaceCnt_q > BURST_W'(1)) spaceCnt_q <= spaceCnt_q - BURST_W'(1);
          else if (guardOk) begin
            convStart_q <= 1'b1;
            state_q     <= ST_CONV;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transfer requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) dmaReq_q <= 1'b0;
    else if (convDone && xfer == XFER_DMA) dmaReq_q <= 1'b1;
    else if (bus.dmaAck) dmaReq_q <= 1'b0;
  end

  assign convStart    = convStart_q;
  assign muxChan      = chan_q;
  assign expSelect    = expSel_q;
  assign bus.rdata    = rdata_q;
  assign bus.dmaReq   = dmaReq_q;
  assign bus.dmaChan3 = ctrl_q[CTRL_DMA3_BIT];
  assign bus.irq      = (xfer == XFER_IRQ && ready_q) ||
                        (!ctrl_q[CTRL_ADCEN_BIT] && src == SRC_INT && tick_q);
  assign bus.tick     = tick_q;

endmodule // adc_pacing_sequencer

// ### src/adc_pacing_host.sv
// Purpose: Host-side controller driving the sequencer register port
// Assumes: software uses the plain command port below
// Notes:   One outstanding access at a time
`timescale 1ns/1ps
module adc_pacing_host
  import adc_pacing_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                reset,
  adc_pacing_if.host               bus,
  input  wire logic [ADDR_W-1:0]   cmdAddr,
  input  wire logic [DATA_W-1:0]   cmdWdata,
  input  wire logic                cmdWr,
  input  wire logic                cmdRd,
  output logic [DATA_W-1:0]        cmdRdata,
  output logic                     irqOut
);
  import adc_pacing_pkg::*;

  logic [ADDR_W-1:0] tgtAddr_q, addr_q;
  logic [DATA_W-1:0] tgtData_q, wdata_q, rdResult_q, dmaWord_q, cmdRdata_q;
  logic              wr_q, rd_q, rdPend_q, dmaAck_q, dmaFlag_q;

  // ----------------------------------------------------------------
  // Command registers
  // ----------------------------------------------------------------
  // Software keeps pacer, burst and gain rates legal
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tgtAddr_q <= '0;
      tgtData_q <= '0;
      addr_q    <= '0;
      wdata_q   <= '0;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      rdPend_q  <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdPend_q <= rd_q;
      if (cmdWr) begin
        case (cmdAddr)
          CMD_ADDR:  tgtAddr_q <= cmdWdata[ADDR_W-1:0];
          CMD_WDATA: tgtData_q <= cmdWdata;
          CMD_GO: begin
            addr_q  <= tgtAddr_q;
            wdata_q <= tgtData_q;
            wr_q    <= cmdWdata[GO_WRITE_BIT];
            rd_q    <= !cmdWdata[GO_WRITE_BIT] && cmdWdata[GO_READ_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) rdResult_q <= '0;
    else if (rdPend_q) rdResult_q <= bus.rdata;
  end

  // Single-cycle DMA acknowledge; the word is captured from the result port
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dmaAck_q  <= 1'b0;
      dmaWord_q <= '0;
      dmaFlag_q <= 1'b0;
    end else begin
      dmaAck_q <= bus.dmaReq && !dmaAck_q;
      if (dmaAck_q) begin
        dmaWord_q <= bus.rdata;
        dmaFlag_q <= 1'b1;
      end else if (cmdRd && cmdAddr == CMD_DMA) dmaFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) cmdRdata_q <= '0;
    else if (cmdRd) begin
      case (cmdAddr)
        CMD_ADDR:  cmdRdata_q <= DATA_W'(tgtAddr_q);
        CMD_WDATA: cmdRdata_q <= tgtData_q;
        CMD_STAT:  cmdRdata_q <= DATA_W'({bus.dmaChan3, dmaFlag_q, bus.irq, rdPend_q | rd_q});
        CMD_RDATA: cmdRdata_q <= rdResult_q;
        CMD_DMA:   cmdRdata_q <= dmaWord_q;
        default:   cmdRdata_q <= '0;
      endcase
    end else cmdRdata_q <= '0;
  end

  assign bus.addr   = addr_q;
  assign bus.wdata  = wdata_q;
  assign bus.wr     = wr_q;
  assign bus.rd     = rd_q;
  assign bus.dmaAck = dmaAck_q;
  assign cmdRdata   = cmdRdata_q;
  assign irqOut     = bus.irq;

endmodule // adc_pacing_host

// ### tb/adc_pacing_chk.sv
// Purpose: Interface checks between sequencer and host controller
// Assumes: one clock, async high reset
// Notes:   Control fields tracked from bus writes
`timescale 1ns/1ps
module adc_pacing_chk
  import adc_pacing_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              irq,
  input wire logic              dmaReq,
  input wire logic              dmaAck,
  input wire logic              dmaChan3,
  input wire logic              tick
);
  logic [DATA_W-1:0] ctrl_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr && addr == REG_CTRL) begin
      ctrl_q <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence ctrlWrite; wr && addr == REG_CTRL; endsequence
  sequence dmaGrant; dmaReq && dmaAck; endsequence
  sequence statusRead; rd && addr == REG_STATUS; endsequence

  data_just_a: assert property (rd && addr == REG_DATA |=> rdata[3:0] == 4'h0)
    else $error("result not left-justified");
  diff_range_a: assert property (statusRead and ctrl_q[CTRL_DIFF_BIT] |=> !rdata[7])
    else $error("channel beyond differential range");
  tick_space_a: assert property (tick |=> !tick [*8])
    else $error("pacer ticks too close");
  dma_hold_a: assert property (dmaReq && !dmaAck |=> dmaReq)
    else $error("dma request dropped before ack");
  dma_release_a: assert property (dmaGrant |-> ##[1:2] !dmaReq)
    else $error("dma request held after ack");
  ack_only_a: assert property (dmaAck |-> dmaReq)
    else $error("ack without request");
  dma_chan_a: assert property (ctrlWrite |=> dmaChan3 == $past(wdata[CTRL_DMA3_BIT]))
    else $error("dma channel select wrong");
  dma_mode_a: assert property ($rose(dmaReq) |-> ctrl_q[4:3] == XFER_DMA)
    else $error("dma request outside dma mode");
  irq_ready_a: assert property (statusRead and ctrl_q[4:3] == XFER_IRQ |=> rdata[0] == $past(irq))
    else $error("irq differs from ready");
  idle_tick_a: assert property (tick && !ctrl_q[CTRL_ADCEN_BIT] && ctrl_q[1:0] == SRC_INT |-> ##[0:2] irq)
    else $error("idle pacer tick without irq");
endmodule // adc_pacing_chk

// ### tb/adc_pacing_sequencer_test.sv
// Purpose: Self-checking bench of sequencer and host pair
// Assumes: fast timebase strap, fast converter
// Notes:   Small divisors keep the run short
`timescale 1ns/1ps
module adc_pacing_sequencer_test;
  import adc_pacing_pkg::*;
  logic                core_clk = 0, reset = 1, pacerPin = 0, convDone = 0, cmdWr = 0, cmdRd = 0;
  logic                convStart, irqOut, dmaPrev = 0, burstOn = 0;
  logic [SAMPLE_W-1:0] convData = '0, lastData = '0;
  logic [ADDR_W-1:0]   cmdAddr = '0;
  logic [DATA_W-1:0]   cmdWdata = '0, cmdRdata, rv;
  logic [CHAN_W-1:0]   muxChan;
  logic [EXP_W-1:0]    expSelect;
  int fails = 0, testsRun = 0, seed = 53065, cyc = 0, nStarts = 0, nDones = 0, nDma = 0;
  int doneCnt = 0, lastStart = -2000, expChan = 6, first = 6, last = 7, expStarts = 0, scanLeft = 0, base;

  adc_pacing_if link();
  adc_pacing_sequencer adc_pacing_sequencer_i (.core_clk(core_clk), .reset(reset), .bus(link.device),
    .pacerPin(pacerPin), .timebaseFast(1'b1), .convDone(convDone), .convData(convData),
    .convStart(convStart), .muxChan(muxChan), .expSelect(expSelect));
  adc_pacing_host adc_pacing_host_i (.core_clk(core_clk), .reset(reset), .bus(link.host), .cmdAddr(cmdAddr),
    .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata), .irqOut(irqOut));
  adc_pacing_chk adc_pacing_chk_i (.core_clk(core_clk), .reset(reset), .addr(link.addr), .wdata(link.wdata),
    .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .irq(link.irq), .dmaReq(link.dmaReq),
    .dmaAck(link.dmaAck), .dmaChan3(link.dmaChan3), .tick(link.tick));

  always #4 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    testsRun++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmdW(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    cmdAddr  <= a;
    cmdWdata <= d;
    cmdWr    <= 1'b1;
    @(posedge core_clk);
    cmdWr <= 1'b0;
  endtask

  task automatic hostR(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    cmdAddr <= a;
    cmdRd   <= 1'b1;
    @(posedge core_clk);
    cmdRd <= 1'b0;
    #1 rv = cmdRdata;
  endtask

  task automatic regW(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    cmdW(CMD_ADDR, 16'(a));
    cmdW(CMD_WDATA, d);
    cmdW(CMD_GO, 16'h0001);
    repeat (3) @(posedge core_clk);
  endtask

  task automatic regR(input logic [ADDR_W-1:0] a);
    cmdW(CMD_ADDR, 16'(a));
    cmdW(CMD_GO, 16'h0002);
    repeat (3) @(posedge core_clk);
    hostR(CMD_RDATA);
  endtask

  task automatic waitDones(input int n);
    while (nDones < n) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // Converter model, pacer model and timeout
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
    convDone <= 1'b0;
    if (doneCnt == 1) begin
      lastData = SAMPLE_W'($random(seed));
      convDone <= 1'b1;
      convData <= lastData;
      nDones++;
      if (scanLeft > 0) scanLeft--;
    end
    if (doneCnt > 0) doneCnt--;
    if (link.dmaReq === 1'b1 && !dmaPrev) nDma++;
    dmaPrev = link.dmaReq;
    // Ticks inside a scan or the start guard are dropped
    if (link.tick === 1'b1 && burstOn && scanLeft == 0 && cyc - lastStart >= CONV_FAST_CYC) begin
      scanLeft = 2;
      expStarts += 2;
    end
    if (link.wr === 1'b1 && link.addr == REG_CTRL)
      burstOn = link.wdata[CTRL_BURST_BIT] && link.wdata[CTRL_ADCEN_BIT] && link.wdata[1:0] == SRC_INT;
    if (convStart === 1'b1) begin
      check(16'(muxChan), 16'(expChan));
      check(16'(cyc - lastStart >= CONV_FAST_CYC), 16'h0001);
      expChan = (expChan == last) ? first : expChan + 1;
      lastStart = cyc;
      nStarts++;
      doneCnt = 20;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    regR(REG_CTRL); check(rv, 16'h0100);
    regR(REG_STATUS); check(rv, 16'h0000);
    regW(4'hC, 16'hFFFF);
    regR(4'hC); check(rv, 16'h0000);
    regW(REG_EXPSEL, 16'h000A); check(16'(expSelect), 16'h000A);
    // Software starts; differential mode first, so the list clamps to 7
    regW(REG_CTRL, 16'h0280);
    regW(REG_CHAN, 16'h0F06);
    for (int i = 1; i <= 4; i++) begin
      regW(REG_SWSTART, 16'h0001);
      waitDones(i);
      regR(REG_DATA); check(rv, {lastData, 4'h0});
      regR(REG_STATUS); check(16'(rv[0]), 16'h0000);
      repeat (CONV_FAST_CYC) @(posedge core_clk);
    end
    // External pacer, interrupt transfer; write strobe refused
    regW(REG_CTRL, 16'h028A);
    regW(REG_SWSTART, 16'h0001);
    repeat (50) @(posedge core_clk);
    check(16'(nStarts), 16'd4);
    for (int i = 0; i < 4; i++) begin
      pacerPin <= ~pacerPin;
      repeat (300) @(posedge core_clk);
    end
    check(16'(nStarts), 16'd5);
    check(16'(irqOut), 16'h0001);
    regR(REG_STATUS);
    regR(REG_DATA); check(rv, {lastData, 4'h0});
    check(16'(irqOut), 16'h0000);
    repeat (CONV_FAST_CYC) @(posedge core_clk);
    pacerPin <= 1'b1;
    waitDones(6);
    pacerPin <= 1'b0;
    // Burst scans paced by internal ticks faster than a scan, DMA out
    base = nStarts;
    regW(REG_DIVLO, 16'd50);
    regW(REG_DIVHI, 16'd2);
    regW(REG_BURST, 16'h0000);
    regW(REG_CTRL, 16'h02D5);
    waitDones(10);
    regW(REG_CTRL, 16'h0001);
    check(16'(nStarts - base), 16'(expStarts));
    check(16'(nDma), 16'd4);
    hostR(CMD_DMA); check(rv, {lastData, 4'h0});
    regR(REG_STATUS); check(16'(rv[0]), 16'h0000);
    repeat (2600) @(posedge core_clk);
    // Hardware gate holds internal pacing until the pin is high
    base = nStarts;
    regW(REG_CTRL, 16'h02A1);
    repeat (3000) @(posedge core_clk);
    check(16'(nStarts - base), 16'd0);
    pacerPin <= 1'b1;
    repeat (3000) @(posedge core_clk);
    check(16'(nStarts > base), 16'h0001);
    end_of_test();
  end
endmodule // adc_pacing_sequencer_test
